// [hdl/pfm_regs.svh]
`ifndef PFM_REGS_SVH
`define PFM_REGS_SVH

// register byte offsets
`define PFM_CTRL_OFS 8'h00
`define PFM_STATUS_OFS 8'h04
`define PFM_WORD_OFS 8'h08

// control register fields
`define PFM_CTRL_CP_EN 0
`define PFM_CTRL_ROLE_MODE 1
`define PFM_CTRL_ROLE_DIR 2
`define PFM_CTRL_AUDIO_EN 3
`define PFM_CTRL_FALL_EDGE 4
`define PFM_CTRL_RESET 5'h08

// status register fields
`define PFM_STAT_BWS_LSB 0
`define PFM_STAT_POWER_DOWN_N 2
`define PFM_STAT_BYPASS 3
`define PFM_STAT_REMOTE 4
`define PFM_STAT_OVF 5
`define PFM_STAT_FULL 6
`define PFM_STAT_EMPTY 7

// pin data bit positions
`define PFM_BIT_HS 18
`define PFM_BIT_VS 19
`define PFM_BIT_DE 20
`define PFM_BIT_WIDE_LSB 21
`define PFM_BIT_WIDE_MSB 26
`define PFM_BIT_AUX1 27
`define PFM_BIT_AUX2 28

// fifo depth
`define PFM_FIFO_DEPTH 32

`endif

// [hdl/pfm_pkg.sv]
package pfm_pkg;

    // three-level bus width select as seen after the pin's level detector
    typedef enum logic [1:0] {
        PFM_BWS_LOW = 2'h0,
        PFM_BWS_HIGH = 2'h1,
        PFM_BWS_OPEN = 2'h3
    } pfm_bws_e;

    // pins driven by the video source
    typedef struct packed {
        logic [28:0] din;
        logic pclk;
        logic sd;
        logic ms;
        logic control_master_side_pin;
        logic power_down_n_n;
        logic [1:0] bus_width_select;
    } pfm_pins_s;

    // one captured pixel word toward the serializer
    typedef struct packed {
        logic [28:0] data;
        logic [28:0] crypt;
        logic hs;
        logic vs;
        logic de;
        logic [3:0] aux;
        logic sd_valid;
        logic sd_bit;
        logic sd_crypt;
    } pfm_word_s;

endpackage

// [hdl/pfm_pin_mux.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pfm_regs.svh"

module pfm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_ptr != rd_ptr;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

module pfm_pin_mux #(
    parameter int FIFO_DEPTH = `PFM_FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire pfm_pkg::pfm_pins_s pins_i,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic word_valid_o,
    input wire logic word_ready_i,
    output pfm_pkg::pfm_word_s word_o,
    output logic capture_ready_o,
    output logic power_down_o,
    output logic bypass_mode_o,
    output logic master_remote_o
);
    import pfm_pkg::*;

    localparam int WW = $bits(pfm_word_s);

    pfm_pins_s pins_meta;
    pfm_pins_s pins_sync;
    logic pclk_prev;
    logic [4:0] ctrl;
    logic ovf;
    logic [28:0] last_data;
    logic bypass_mode;
    logic master_remote;
    logic pclk_edge;
    logic capture;
    logic hb_mode;
    logic wide_mode;
    logic strobes;
    logic cp_en;
    pfm_word_s next_word;
    logic [7:0] wr_addr;
    logic wr_pend;
    logic rd_take;
    logic [31:0] next_rdata;
    logic fifo_full;
    logic fifo_empty;

    // pins come from the source's pixel clock domain
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pins_meta <= '0;
            pins_sync <= '0;
        end
        else
        begin
            pins_meta <= pins_i;
            pins_sync <= pins_meta;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pclk_prev <= 1'b0;
        end
        else
        begin
            pclk_prev <= pins_sync.pclk;
        end
    end

    // edge select picks rising or falling pixel clock edge
    assign pclk_edge = ctrl[`PFM_CTRL_FALL_EDGE] ?
        (pclk_prev && !pins_sync.pclk) : (!pclk_prev && pins_sync.pclk);
    assign capture = pclk_edge && pins_sync.power_down_n_n;

    assign cp_en = ctrl[`PFM_CTRL_CP_EN];
    assign hb_mode = pins_sync.bus_width_select == PFM_BWS_OPEN;
    assign wide_mode = pins_sync.bus_width_select == PFM_BWS_HIGH;
    assign strobes = cp_en || hb_mode;

    always_comb
    begin
        next_word = '0;
        next_word.data[17:0] = pins_sync.din[17:0];
        next_word.crypt[17:0] = {18{cp_en}};
        // sync strobes replace data bits 18-20
        if (strobes)
        begin
            next_word.hs = pins_sync.din[`PFM_BIT_HS];
            next_word.vs = pins_sync.din[`PFM_BIT_VS];
            next_word.de = pins_sync.din[`PFM_BIT_DE];
        end
        else
        begin
            next_word.data[`PFM_BIT_DE:`PFM_BIT_HS] =
                pins_sync.din[`PFM_BIT_DE:`PFM_BIT_HS];
            next_word.crypt[`PFM_BIT_DE:`PFM_BIT_HS] = {3{cp_en}};
        end
        // upper bits 21-28 are dropped in base mode
        if (wide_mode || hb_mode)
        begin
            next_word.data[`PFM_BIT_WIDE_MSB:`PFM_BIT_WIDE_LSB] =
                pins_sync.din[`PFM_BIT_WIDE_MSB:`PFM_BIT_WIDE_LSB];
            next_word.crypt[`PFM_BIT_WIDE_MSB:`PFM_BIT_WIDE_LSB] = {6{cp_en}};
        end
        if (wide_mode)
        begin
            next_word.data[`PFM_BIT_AUX1] = pins_sync.din[`PFM_BIT_AUX1];
            next_word.data[`PFM_BIT_AUX2] = pins_sync.din[`PFM_BIT_AUX2];
        end
        if (hb_mode)
        begin
            next_word.aux[1] = pins_sync.din[`PFM_BIT_AUX1];
            next_word.aux[2] = pins_sync.din[`PFM_BIT_AUX2];
            next_word.aux[0] = ctrl[`PFM_CTRL_ROLE_MODE] && pins_sync.ms;
            next_word.aux[3] = ctrl[`PFM_CTRL_ROLE_DIR] && pins_sync.control_master_side_pin;
        end
        // serial-data pin doubles as a control input only with audio off
        if (!ctrl[`PFM_CTRL_AUDIO_EN])
        begin
            next_word.sd_valid = 1'b1;
            next_word.sd_bit = pins_sync.sd;
            next_word.sd_crypt = cp_en;
        end
    end

    // mode and direction roles follow the pins only while their ctrl role bits are clear
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bypass_mode <= 1'b0;
        end
        else if (!ctrl[`PFM_CTRL_ROLE_MODE])
        begin
            bypass_mode <= pins_sync.ms;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            master_remote <= 1'b0;
        end
        else if (!ctrl[`PFM_CTRL_ROLE_DIR])
        begin
            master_remote <= pins_sync.control_master_side_pin;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            power_down_o <= 1'b0;
        end
        else
        begin
            power_down_o <= !pins_sync.power_down_n_n;
        end
    end

    assign bypass_mode_o = bypass_mode;
    assign master_remote_o = master_remote;

    // the pins cannot be stalled, so a word meeting a full fifo is lost and flagged
    pfm_fifo #(
        .WIDTH(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .in_valid_i(capture),
        .in_ready_o(capture_ready_o),
        .in_data_i(next_word),
        .out_valid_o(word_valid_o),
        .out_ready_i(word_ready_i),
        .out_data_o(word_o)
    );

    assign fifo_full = !capture_ready_o;
    assign fifo_empty = !word_valid_o;

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            last_data <= '0;
        end
        // a word dropped at a full fifo was never captured, so it does not show here
        else if (capture && !fifo_full)
        begin
            last_data <= next_word.data;
        end
    end

    // ahb-lite slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign rd_take = hsel && htrans[1] && hready && !hwrite;

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end
        else if (hready)
        begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl <= `PFM_CTRL_RESET;
        end
        else if (wr_pend && wr_addr == `PFM_CTRL_OFS)
        begin
            ctrl <= hwdata[4:0];
        end
    end

    // overflow: a new loss wins over a same-cycle write-one clear
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ovf <= 1'b0;
        end
        else if (capture && fifo_full)
        begin
            ovf <= 1'b1;
        end
        else if (wr_pend && wr_addr == `PFM_STATUS_OFS && hwdata[`PFM_STAT_OVF])
        begin
            ovf <= 1'b0;
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (haddr[7:0])
            `PFM_CTRL_OFS:
            begin
                next_rdata[4:0] = ctrl;
            end
            `PFM_STATUS_OFS:
            begin
                next_rdata[`PFM_STAT_BWS_LSB +: 2] = pins_sync.bus_width_select;
                next_rdata[`PFM_STAT_POWER_DOWN_N] = power_down_o;
                next_rdata[`PFM_STAT_BYPASS] = bypass_mode;
                next_rdata[`PFM_STAT_REMOTE] = master_remote;
                next_rdata[`PFM_STAT_OVF] = ovf;
                next_rdata[`PFM_STAT_FULL] = fifo_full;
                next_rdata[`PFM_STAT_EMPTY] = fifo_empty;
            end
            `PFM_WORD_OFS:
            begin
                next_rdata[28:0] = last_data;
            end
            default:
            begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // read data is registered at the address phase and stands in the data phase
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            hrdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// [testbench/pfm_pin_mux_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module pfm_pin_mux_properties (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire pfm_pkg::pfm_pins_s pins_i,
    input wire logic word_valid_o,
    input wire logic word_ready_i,
    input wire pfm_pkg::pfm_word_s word_o,
    input wire logic capture_ready_o,
    input wire logic power_down_o,
    input wire logic bypass_mode_o,
    input wire logic master_remote_o
);
    import pfm_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // pins pass a two-stage synchroniser, so outputs trail them by three edges
    pd_enter_a: assert property (!pins_i.power_down_n_n [*4] |-> power_down_o)
        else $error("power down missed");
    pd_idle_a: assert property (power_down_o && !word_valid_o |=> !word_valid_o || !power_down_o)
        else $error("capture in power down");
    bypass_rise_a: assert property ($rose(bypass_mode_o) |-> $past(pins_i.ms, 3))
        else $error("bypass without mode pin");
    remote_rise_a: assert property ($rose(master_remote_o) |-> $past(pins_i.control_master_side_pin, 3))
        else $error("remote without direction pin");
    head_hold_a: assert property (word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o))
        else $error("head word moved");
    full_flag_a: assert property (!capture_ready_o |-> word_valid_o)
        else $error("full while empty");
    base_drop_a: assert property ($rose(word_valid_o) && $past(pins_i.bus_width_select, 4) == PFM_BWS_LOW
        |-> word_o.data[28:21] == 8'h00 && word_o.aux == 4'h0)
        else $error("upper bits kept in base mode");
    aux_pins_a: assert property ($rose(word_valid_o) && $past(pins_i.bus_width_select, 4) == PFM_BWS_OPEN
        |-> word_o.aux[2:1] == $past(pins_i.din[28:27], 3) && word_o.data[28:27] == 2'h0)
        else $error("aux pins wrong");
    plain_hi_a: assert property (word_valid_o |-> word_o.crypt[28:27] == 2'h0)
        else $error("top bits encrypted");
endmodule
bind pfm_pin_mux pfm_pin_mux_properties i_props (.clk_sys_i, .resetn_i, .pins_i, .word_valid_o,
    .word_ready_i, .word_o, .capture_ready_o, .power_down_o, .bypass_mode_o, .master_remote_o);
`default_nettype wire

// [testbench/pfm_video_source.sv]
`timescale 1ns/10ps
`default_nettype none
module pfm_video_source (
    input wire logic go_i,
    input wire pfm_pkg::pfm_pins_s cfg_i,
    output pfm_pkg::pfm_pins_s pins_o
);
    import pfm_pkg::*;
    logic [28:0] din = '0;
    logic pclk = 0;
    logic sd = 0;
    // static levels pass straight through
    assign pins_o = {din, pclk, sd, cfg_i.ms, cfg_i.control_master_side_pin, cfg_i.power_down_n_n, cfg_i.bus_width_select};
    // one pixel per request; clock stands low between pixels
    always @(posedge go_i)
    begin
        din = cfg_i.din;
        sd = cfg_i.sd;
        #400 pclk = 1;
        #400 pclk = 0;
        #400 din = '0; // released lines fall to their pulldown
        sd = 0;
    end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pfm_regs.svh"
module testbench;
    import pfm_pkg::*;
    logic clk_sys_i = 0, resetn_i = 0, hsel = 0, hwrite = 0, go = 0, rdy = 1;
    logic [31:0] haddr = 0, hwdata = 0, seed = 13, r, hrdata;
    logic [1:0] htrans = 0;
    logic [4:0] ctrl = 5'h08;
    logic hreadyout, wv, cr, pd, byp, mr;
    logic [28:0] lastd;
    pfm_pins_s cfg = 36'h4, pins;
    pfm_word_s wo, e, g, x, q[$];
    int n_mismatch = 0, total_checks = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    pfm_video_source i_pfm_video_source (.go_i(go), .cfg_i(cfg), .pins_o(pins));
    pfm_pin_mux #(.FIFO_DEPTH(32)) i_pfm_pin_mux (.clk_sys_i, .resetn_i, .pins_i(pins), .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
        .hresp(), .hrdata, .word_valid_o(wv), .word_ready_i(rdy), .word_o(wo),
        .capture_ready_o(cr), .power_down_o(pd), .bypass_mode_o(byp), .master_remote_o(mr));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic pfm_word_s expw(logic [4:0] c, pfm_pins_s p);
        pfm_word_s w;
        logic op;
        w = '0;
        op = p.bus_width_select == PFM_BWS_OPEN;
        w.data[17:0] = p.din[17:0];
        w.crypt[17:0] = {18{c[0]}};
        if (c[0] | op)
            {w.de, w.vs, w.hs} = p.din[20:18];
        else
            {w.data[20:18], w.crypt[20:18]} = {p.din[20:18], 3'h0};
        if (op | p.bus_width_select == PFM_BWS_HIGH)
            {w.data[26:18], w.crypt[26:18]} = {p.din[26:21], w.data[20:18], {6{c[0]}}, w.crypt[20:18]};
        if (p.bus_width_select == PFM_BWS_HIGH)
            w.data[28:27] = p.din[28:27];
        if (op)
            w.aux = {c[2] & p.control_master_side_pin, p.din[28:27], c[1] & p.ms};
        {w.sd_valid, w.sd_bit, w.sd_crypt} = {!c[3], p.sd & !c[3], c[0] & !c[3]};
        if (!(c[0] | op))
            w.crypt[20:18] = {3{c[0]}};
        return w;
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [67:0] s, input logic [67:0] x);
        total_checks++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        hsel <= 1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        for (int k = 0; k < 2; k++)
        begin
            i = 0;
            do
            begin
                @(posedge clk_sys_i);
                i++;
            end while (hreadyout !== 1'b1 && i < 50);
            if (i == 50)
                chk("bus wait", 1, 0);
            if (i == 50)
                results();
            if (k == 0)
            begin
                hsel <= 0;
                htrans <= 2'h0;
                hwdata <= d;
            end
        end
        r = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        bus(0, a, 0);
        chk("register", r & m, v);
    endtask
    task automatic wr(input logic [4:0] c);
        ctrl <= c;
        bus(1, `PFM_CTRL_OFS, {27'h0, c});
    endtask
    // one pixel; n says whether a word is expected from it
    task automatic px(input logic n);
        r = rnd();
        cfg.din <= r[28:0];
        {cfg.sd, cfg.ms, cfg.control_master_side_pin} <= r[31:29];
        @(posedge clk_sys_i);
        x = expw(ctrl, cfg);
        go <= 1;
        if (n)
            q.push_back(x);
        if (n)
            lastd <= x.data;
        repeat (14) @(posedge clk_sys_i);
        go <= 0;
    endtask
    task automatic drain();
        for (int i = 0; i < 200 && q.size() > 0; i++)
            @(posedge clk_sys_i);
        chk("words left", q.size(), 0);
        if (q.size() > 0)
            results();
    endtask
    always @(posedge clk_sys_i)
        if (wv === 1'b1 && rdy)
        begin
            g = wo;
            if (q.size() == 0)
                chk("spare word", 1, 0);
            else
            begin
                e = q.pop_front();
                {g.sd_bit, g.sd_crypt} &= {2{e.sd_valid}};
                chk("word", g, e);
            end
        end
    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        resetn_i <= 1;
        @(posedge clk_sys_i);
        rd(`PFM_CTRL_OFS, 32'h08, 32'hFF);
        rd(8'h0C, 32'h0, 32'hFFFFFFFF);
        $display("test registers done");
        for (int m = 0; m < 32; m++)
        begin
            cfg.bus_width_select <= m[1:0];
            wr({m[4] ^ m[3], m[4], m[3], m[3], m[2]});
            px(1);
            px(1);
        end
        drain();
        $display("test pin modes done");
        cfg.power_down_n_n <= 0;
        repeat (5) @(posedge clk_sys_i);
        chk("power_down_o", pd, 1);
        px(0);
        cfg.power_down_n_n <= 1;
        repeat (5) @(posedge clk_sys_i);
        chk("power_down_o", pd, 0);
        $display("test power down done");
        wr(5'h08);
        {cfg.ms, cfg.control_master_side_pin} <= 2'b11;
        repeat (5) @(posedge clk_sys_i);
        chk("mode outputs", {byp, mr}, 2'b11);
        wr(5'h0E);
        {cfg.ms, cfg.control_master_side_pin} <= 2'b00;
        repeat (5) @(posedge clk_sys_i);
        chk("mode outputs", {byp, mr}, 2'b11);
        wr(5'h08);
        repeat (5) @(posedge clk_sys_i);
        chk("mode outputs", {byp, mr}, 2'b00);
        $display("test pin roles done");
        cfg.bus_width_select <= PFM_BWS_HIGH;
        rdy <= 0;
        for (int i = 0; i < 33; i++)
            px(i < 32);
        chk("capture_ready_o", cr, 0);
        rd(`PFM_STATUS_OFS, 32'h61, 32'hE3);
        rdy <= 1;
        drain();
        bus(1, `PFM_STATUS_OFS, 32'h20);
        rd(`PFM_STATUS_OFS, 32'h80, 32'hE0);
        rd(`PFM_WORD_OFS, {3'h0, lastd}, 32'h1FFFFFFF);
        $display("test overflow done");
        results();
    end
endmodule
`default_nettype wire
